// [src/csp_pkg.sv]
// Package: frame layout, widths, reset values, states and carriers for the serial PWM LED driver
package csp_pkg;

   // ----------------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------------
   localparam int          CSP_CHANNELS     = 4;
   localparam int          CSP_MULT_W       = 12;
   localparam int          CSP_GRAY_W       = 10;
   localparam int          CSP_FIELD_W      = 12;
   localparam int          CSP_WORD_W       = 48;
   localparam int          CSP_PWM_W        = 22;
   localparam logic [4:0]  CSP_START_ONES   = 5'h10;   // Begin marker run length
   localparam logic [1:0]  CSP_LEAD         = 2'h1;    // Leading pattern 01
   localparam logic [5:0]  CSP_MULT_LAST    = 6'h0B;   // Last multiplier bit index
   localparam logic [5:0]  CSP_WORD_LAST    = 6'h2F;   // Last data word bit index
   localparam logic [5:0]  CSP_REEMIT_ZERO  = 6'h22;   // Word slot where the re-sent lead 0 goes
   localparam logic [5:0]  CSP_REEMIT_ONE   = 6'h23;   // Word slot where the re-sent lead 1 goes

   // ----------------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------------
   localparam logic [11:0] CSP_MULT_RST     = 12'h000;
   localparam logic [39:0] CSP_GRAY_RST     = 40'h00_0000_0000;

   // ----------------------------------------------------------------------
   // Receiver states
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      CSP_ST_HUNT = 5'b00001,
      CSP_ST_GAP  = 5'b00010,
      CSP_ST_MULT = 5'b00100,
      CSP_ST_WORD = 5'b01000,
      CSP_ST_PASS = 5'b10000
   } csp_rx_state_t;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] mult;
      logic [39:0] gray;
   } csp_values_t;

   typedef struct packed {
      csp_rx_state_t st;
      logic [4:0]    ones;
      logic [5:0]    bits;
      logic [46:0]   sh;
      logic [11:0]   mult_cap;
      csp_values_t   pend;
      logic          latch_tgl;
      logic          apply_seen;
      logic          dout;
   } csp_link_t;

   typedef struct packed {
      logic        tgl_seen;
      logic        strobe;
      logic        apply_tgl;
      csp_values_t held;
      logic        shut;
      logic [3:0]  out;
   } csp_sys_t;

endpackage

// [src/csp_sync.sv]
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module csp_sync
   import csp_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } csp_sync_t;

   csp_sync_t st_r;
   csp_sync_t st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
   end

   // State registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_out = st_r.s2;

endmodule

// [src/csp_pwm_chan.sv]
// One PWM channel counted in serial clock periods
`timescale 1ns/1ps
module csp_pwm_chan
   import csp_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        restart_in,
   input  wire logic [11:0] mult_in,
   input  wire logic [9:0]  gray_in,
   output logic             on_out
);

   typedef struct packed {
      logic [CSP_PWM_W-1:0] cnt;
      logic                 on;
   } csp_pwm_t;

   csp_pwm_t             st_r;
   csp_pwm_t             st_nxt;
   logic [CSP_PWM_W-1:0] prod;

   assign prod = mult_in * gray_in;

   // Reload on a fresh apply, else count down to zero
   always_comb begin
      st_nxt = st_r;
      if (restart_in) begin
         st_nxt.cnt = prod;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - CSP_PWM_W'(1);
      end
      st_nxt.on = (st_nxt.cnt != '0);
   end

   // State registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign on_out = st_r.on;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_PWM_RELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
      restart_in |=> (st_r.cnt == $past(prod)) && (on_out == ($past(prod) != '0)))
      else $error("pwm counter did not reload on apply");

   AST_PWM_WIDTH: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(on_out) |-> ($past(st_r.cnt) == CSP_PWM_W'(1)) || $past(restart_in))
      else $error("pwm pulse ended before its count ran out");

   COV_PWM_PULSE: cover property (@(posedge clk_in) disable iff (rst_in)
      restart_in ##1 on_out ##[1:20] !on_out);

endmodule

// [src/csp_led_driver.sv]
// Top of the serial PWM LED driver: frame receiver, chain forwarding, latch and output gating
`timescale 1ns/1ps
module csp_led_driver
   import csp_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       serial_clock_in,
   input  wire logic       serial_bit_in,
   input  wire logic       temp_above_upper_in,
   input  wire logic       temp_below_lower_in,
   output logic            inverted_clock_forward_out,
   output logic            serial_bit_out,
   output logic [3:0]      sink_channel_out,
   output logic            output_latch_strobe_out,
   output logic            shutdown_out
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   csp_link_t   lk_r;
   csp_link_t   lk_nxt;
   csp_sys_t    sy_r;
   csp_sys_t    sy_nxt;
   logic        link_rdy;
   logic        link_rst;
   logic        run_full;
   logic        apply_sync;
   logic        restart;
   logic        latch_sync;
   logic [1:0]  temp_sync;
   logic [3:0]  pwm_on;
   logic [3:0]  pwm_on_sync;
   logic [47:0] word_full;
   logic [3:0]  lead_ok;
   logic [39:0] gray_new;

   // ----------------------------------------------------------------------
   // Link-domain reset: asserts at once, releases on the serial clock
   // ----------------------------------------------------------------------
   csp_sync #(
      .W (1)
   ) u_link_rst (
      .clk_in (serial_clock_in),
      .rst_in (rst_in),
      .d_in   (1'b1),
      .q_out  (link_rdy)
   );

   assign link_rst = ~link_rdy;

   // Clock for the next device is a plain inversion, no retiming
   assign inverted_clock_forward_out = ~serial_clock_in;

   // ----------------------------------------------------------------------
   // Field split of the word being completed
   // ----------------------------------------------------------------------
   assign word_full = {lk_r.sh, serial_bit_in};

   // Channel 0 is the first field on the wire
   generate
      for (genvar i = 0; i < CSP_CHANNELS; i++) begin : g_field
         localparam int HI = CSP_WORD_W - 1 - CSP_FIELD_W * i;
         assign lead_ok[i] = (word_full[HI -: 2] == CSP_LEAD);
         assign gray_new[39 - CSP_GRAY_W * i -: CSP_GRAY_W] = word_full[HI - 2 -: CSP_GRAY_W];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Frame receiver and chain forwarding (serial clock domain)
   // ----------------------------------------------------------------------
   assign run_full = (lk_r.ones == CSP_START_ONES);
   assign restart  = apply_sync ^ lk_r.apply_seen;

   // Next state of the receiver
   always_comb begin
      lk_nxt            = lk_r;
      lk_nxt.sh         = word_full[46:0];
      lk_nxt.bits       = lk_r.bits + 6'h01;
      lk_nxt.apply_seen = apply_sync;
      // Saturating run counter; data fields never hold sixteen ones
      if (!serial_bit_in) begin
         lk_nxt.ones = 5'h00;
      end else if (!run_full) begin
         lk_nxt.ones = lk_r.ones + 5'h01;
      end
      // Outside our slot, hide the marker's trailing lead so the next device
      // never sees a header before the one we re-send
      lk_nxt.dout = serial_bit_in | run_full;
      unique case (lk_r.st)
         CSP_ST_HUNT, CSP_ST_PASS: begin
            if (run_full && !serial_bit_in) begin
               lk_nxt.st = CSP_ST_GAP;
            end
         end
         CSP_ST_GAP: begin
            lk_nxt.dout = 1'b1;
            if (serial_bit_in) begin
               // Lead 1 of the multiplier: frame start, values fall due
               lk_nxt.st        = CSP_ST_MULT;
               lk_nxt.bits      = 6'h00;
               lk_nxt.ones      = 5'h00;
               lk_nxt.latch_tgl = ~lk_r.latch_tgl;
            end else begin
               lk_nxt.st = CSP_ST_HUNT;
            end
         end
         CSP_ST_MULT: begin
            lk_nxt.dout = 1'b1;
            if (lk_r.bits == CSP_MULT_LAST) begin
               lk_nxt.mult_cap = word_full[11:0];
               lk_nxt.st       = CSP_ST_WORD;
               lk_nxt.bits     = 6'h00;
            end
         end
         CSP_ST_WORD: begin
            // Our slot: send ones, then a fresh lead and the multiplier,
            // so the next device finds its header right before its word
            if (lk_r.bits < CSP_REEMIT_ZERO) begin
               lk_nxt.dout = 1'b1;
            end else if (lk_r.bits == CSP_REEMIT_ZERO) begin
               lk_nxt.dout = 1'b0;
            end else if (lk_r.bits == CSP_REEMIT_ONE) begin
               lk_nxt.dout = 1'b1;
            end else begin
               lk_nxt.dout = lk_r.mult_cap[4'(CSP_WORD_LAST - lk_r.bits)];
            end
            if (lk_r.bits == CSP_WORD_LAST) begin
               lk_nxt.st = CSP_ST_PASS;
               // A word with a broken lead is dropped; old values stand
               if (&lead_ok) begin
                  lk_nxt.pend.mult = lk_r.mult_cap;
                  lk_nxt.pend.gray = gray_new;
               end
            end
         end
         default: begin
            lk_nxt.st = CSP_ST_HUNT;
         end
      endcase
   end

   // Receiver registers, sampled on the rising serial edge
   always_ff @(posedge serial_clock_in or posedge link_rst) begin
      if (link_rst) begin
         lk_r            <= '0;
         lk_r.st         <= CSP_ST_HUNT;
         lk_r.pend.mult  <= CSP_MULT_RST;
         lk_r.pend.gray  <= CSP_GRAY_RST;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   assign serial_bit_out = lk_r.dout;

   // ----------------------------------------------------------------------
   // Crossings between the two domains
   // ----------------------------------------------------------------------
   // Frame-start toggle into the system clock
   csp_sync #(
      .W (1)
   ) u_latch_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   (lk_r.latch_tgl),
      .q_out  (latch_sync)
   );

   // Apply toggle back to the serial clock
   csp_sync #(
      .W (1)
   ) u_apply_sync (
      .clk_in (serial_clock_in),
      .rst_in (link_rst),
      .d_in   (sy_r.apply_tgl),
      .q_out  (apply_sync)
   );

   // Thermal comparator levels
   csp_sync #(
      .W (2)
   ) u_temp_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({temp_above_upper_in, temp_below_lower_in}),
      .q_out  (temp_sync)
   );

   // Channel levels from the PWM counters
   csp_sync #(
      .W (4)
   ) u_pwm_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   (pwm_on),
      .q_out  (pwm_on_sync)
   );

   // ----------------------------------------------------------------------
   // Latch strobe, value transfer and thermal gating (system clock)
   // ----------------------------------------------------------------------
   // Pending values are quiet from frame start until the next word ends,
   // which is far longer than the toggle takes to cross
   always_comb begin
      sy_nxt          = sy_r;
      sy_nxt.tgl_seen = latch_sync;
      sy_nxt.strobe   = (latch_sync != sy_r.tgl_seen);
      if (sy_r.strobe && !sy_nxt.strobe) begin
         sy_nxt.held      = lk_r.pend;
         sy_nxt.apply_tgl = ~sy_r.apply_tgl;
      end
      // Hysteresis: set above the upper point, clear below the lower one
      if (temp_sync[1]) begin
         sy_nxt.shut = 1'b1;
      end else if (temp_sync[0]) begin
         sy_nxt.shut = 1'b0;
      end
      sy_nxt.out = sy_r.shut ? 4'h0 : pwm_on_sync;
   end

   // System registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sy_r           <= '0;
         sy_r.held.mult <= CSP_MULT_RST;
         sy_r.held.gray <= CSP_GRAY_RST;
      end else begin
         sy_r <= sy_nxt;
      end
   end

   assign sink_channel_out        = sy_r.out;
   assign output_latch_strobe_out = sy_r.strobe;
   assign shutdown_out            = sy_r.shut;

   // ----------------------------------------------------------------------
   // PWM counters, one per channel, on the serial clock
   // ----------------------------------------------------------------------
   // No refresh timer: the marker spacing alone restarts the counters
   generate
      for (genvar c = 0; c < CSP_CHANNELS; c++) begin : g_pwm
         csp_pwm_chan u_chan (
            .clk_in     (serial_clock_in),
            .rst_in     (link_rst),
            .restart_in (restart),
            .mult_in    (sy_r.held.mult),
            .gray_in    (sy_r.held.gray[39 - CSP_GRAY_W * c -: CSP_GRAY_W]),
            .on_out     (pwm_on[c])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_CLK_INVERT: assert property (@(posedge clk_in) disable iff (rst_in)
      inverted_clock_forward_out == !serial_clock_in)
      else $error("forwarded clock is not the inverse of the input clock");

   AST_START_LEAD: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_GAP && serial_bit_in) |=>
         (lk_r.st == CSP_ST_MULT) && (lk_r.latch_tgl != $past(lk_r.latch_tgl)))
      else $error("lead one after the marker did not open a frame");

   // Length held by the bit counter, so no long repetition is needed
   AST_MULT_LEN: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_MULT && lk_r.bits == 6'h00) |->
         ##11 (lk_r.st == CSP_ST_MULT && lk_r.bits == CSP_MULT_LAST) ##1 (lk_r.st == CSP_ST_WORD))
      else $error("multiplier field is not twelve bits");

   AST_WORD_LEN: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_WORD && lk_r.bits == 6'h00) |->
         ##47 (lk_r.st == CSP_ST_WORD) ##1 (lk_r.st == CSP_ST_PASS))
      else $error("own data word is not forty-eight bits");

   AST_OWN_CAPTURE: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_WORD && lk_r.bits == CSP_WORD_LAST && (&lead_ok)) |=>
         (lk_r.pend.gray[39:30] == $past(lk_r.sh[44:35])) && (lk_r.pend.mult == $past(lk_r.mult_cap)))
      else $error("first field of own word not captured for channel 0");

   // A dropped word must leave the pending values untouched
   AST_DROP_KEEP: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_WORD && lk_r.bits == CSP_WORD_LAST && !(&lead_ok)) |=> $stable(lk_r.pend))
      else $error("word with a broken lead overwrote pending values");

   AST_REEMIT_LEAD: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      (lk_r.st == CSP_ST_WORD && lk_r.bits == CSP_REEMIT_ZERO) |=> !serial_bit_out ##1 serial_bit_out)
      else $error("re-sent lead pattern is wrong");

   AST_MARKER_MASK: assert property (@(posedge serial_clock_in) disable iff (link_rst)
      run_full |=> serial_bit_out)
      else $error("marker lead leaked downstream");

   AST_STROBE_APPLY: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(sy_r.strobe) |-> (sy_r.held == $past(lk_r.pend)) && (sy_r.apply_tgl != $past(sy_r.apply_tgl)))
      else $error("values not applied on strobe fall");

   AST_STROBE_SHORT: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(sy_r.strobe) |=> !sy_r.strobe)
      else $error("latch strobe longer than one cycle");

   AST_SHUT_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
      sy_r.shut |=> (sink_channel_out == 4'h0))
      else $error("outputs active during thermal shutdown");

   AST_SHUT_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      (sy_r.shut && !temp_sync[0]) |=> sy_r.shut)
      else $error("shutdown released above the lower threshold");

   // Release must follow the lower mark when the upper one is quiet
   AST_SHUT_RELEASE: assert property (@(posedge clk_in) disable iff (rst_in)
      (sy_r.shut && temp_sync[0] && !temp_sync[1]) |=> !sy_r.shut)
      else $error("shutdown not released below the lower threshold");

   COV_FRAME_START: cover property (@(posedge serial_clock_in) disable iff (link_rst)
      lk_r.st == CSP_ST_GAP ##1 lk_r.st == CSP_ST_MULT);

   COV_PASS: cover property (@(posedge serial_clock_in) disable iff (link_rst)
      lk_r.st == CSP_ST_WORD ##1 lk_r.st == CSP_ST_PASS);

   COV_APPLY: cover property (@(posedge clk_in) disable iff (rst_in)
      $fell(sy_r.strobe));

   COV_SHUT: cover property (@(posedge clk_in) disable iff (rst_in)
      $rose(sy_r.shut) ##[1:1000] $fell(sy_r.shut));

endmodule

// [verif/csp_ctrl_model.sv]
// Upstream controller model: serial clock and framed bit stream
`timescale 1ns/1ps
module csp_ctrl_model (
   output logic sclk_out,
   output logic sdat_out
);
   int nbit;

   // Clock stands low between frames
   initial begin
      sclk_out = 1'b0;
      sdat_out = 1'b0;
      nbit     = -1;
   end

   // ----------------------------------------------------------------
   // Bit and frame sending
   // ----------------------------------------------------------------
   // Data moves while the clock is low, so it is settled at the rise
   task automatic bit_tx(input logic b);
      #1 sdat_out = b;
      nbit++;
      #61.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
   endtask

   // Zeros with a running clock; the line flips once the clock stops
   task automatic idle(input int n);
      repeat (n) bit_tx(1'b0);
      sdat_out = ~sdat_out;
   endtask

   // Marker, lead, multiplier, two words, then the tail
   task automatic frame(input logic [11:0] m, input logic [47:0] w0, input logic [47:0] w1, input int tail);
      nbit = -1;
      repeat (16) bit_tx(1'b1);
      bit_tx(1'b0);
      bit_tx(1'b1);
      for (int i = 11; i >= 0; i--) bit_tx(m[i]);
      for (int i = 47; i >= 0; i--) bit_tx(w0[i]);
      for (int i = 47; i >= 0; i--) bit_tx(w1[i]);
      idle(tail);
   endtask
endmodule

// [verif/tb.sv]
// Testbench: framing, forwarding, pulse widths and thermal shutdown
`timescale 1ns/1ps
module tb
   import csp_pkg::*;
;
   logic        clk_in;
   logic        rst_in;
   logic        sclk;
   logic        sdat;
   logic        hot;
   logic        cool;
   logic        fwd_clk;
   logic        sdo;
   logic [3:0]  sink;
   logic        strobe;
   logic        shut;
   logic [47:0] wa;
   logic [47:0] wb;
   logic [47:0] wc;
   logic        fwd [200];
   int          hcnt [4];
   int          n_strobe;
   int          n_errors;
   int          checked;

   csp_ctrl_model ctrl (.sclk_out(sclk), .sdat_out(sdat));
   csp_led_driver dut (
      .clk_in(clk_in), .rst_in(rst_in),
      .serial_clock_in(sclk), .serial_bit_in(sdat),
      .temp_above_upper_in(hot), .temp_below_lower_in(cool),
      .inverted_clock_forward_out(fwd_clk), .serial_bit_out(sdo),
      .sink_channel_out(sink), .output_latch_strobe_out(strobe),
      .shutdown_out(shut)
   );

   // ----------------------------------------------------------------
   // Clock and monitors
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // Tally channel on time and strobes per clk_in cycle
   always @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) hcnt[i] += (sink[i] !== 1'b0);
      n_strobe += (strobe !== 1'b0);
   end

   // Next device samples on the rise of the inverted clock
   always @(negedge sclk) begin
      if (ctrl.nbit >= 0 && ctrl.nbit < 200) fwd[ctrl.nbit] = sdo;
   end

   // Serial edges meet a falling clk_in edge only once, at the last clock fall of the opening idle
   always @(negedge clk_in) begin
      if (!rst_in) chk("fwd_clk", !sclk, fwd_clk);
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic near(input string nm, input int e, input int g);
      checked++;
      if (g < e - 3 || g > e + 3) begin
         n_errors++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   function automatic logic [47:0] mk(input logic [9:0] a, b, c, d);
      return {CSP_LEAD, a, CSP_LEAD, b, CSP_LEAD, c, CSP_LEAD, d};
   endfunction

   // Serial periods of 125 ns turned into clk_in cycles; sync lag cancels
   task automatic widths(input int m, input int g0, input int g1, input int g2, input int g3);
      int g [4];
      g = '{g0, g1, g2, g3};
      for (int i = 0; i < 4; i++) near($sformatf("width%0d", i), (m * g[i] * 125 + 20) / 40, hcnt[i]);
      chk("strobes", 32'h1, n_strobe);
   endtask

   task automatic clr();
      @(posedge clk_in);
      #2;
      n_strobe = 0;
      for (int i = 0; i < 4; i++) hcnt[i] = 0;
   endtask

   // Bounded wait on the shutdown level
   task automatic wait_shut(input logic v);
      int k;
      k = 0;
      while (shut !== v && k < 50) begin
         @(posedge clk_in);
         k++;
      end
      chk("shutdown", v, shut);
      if (shut !== v) conclude();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("sink", 32'h0, sink);
      chk("strobe", 32'h0, strobe);
      chk("fwd_bit", 32'h0, sdo);
      $display("test reset done");
   endtask

   // First frame: reset values apply, own word kept, rest forwarded
   task automatic t_forward();
      logic [11:0] m;
      logic        e;
      m = 12'h003;
      clr();
      ctrl.frame(m, wa, wb, 40);
      widths(0, 0, 0, 0, 0);
      for (int i = 0; i < 126; i++) begin
         e = (i < 64) ? 1'b1 : (i == 64) ? 1'b0 : (i == 65) ? 1'b1 : (i < 78) ? m[77 - i] : wb[125 - i];
         chk("fwd_bit", e, fwd[i]);
      end
      $display("test forward done");
   endtask

   // Second frame shows the first frame's values
   task automatic t_pwm();
      clr();
      ctrl.frame(12'h007, wc, wb, 80);
      widths(3, 0, 1, 5, 20);
      $display("test pwm done");
   endtask

   // Overheat masks outputs; bad word dropped; release needs the low mark
   task automatic t_thermal();
      @(posedge clk_in);
      #2 hot = 1'b1;
      wait_shut(1'b1);
      clr();
      ctrl.frame(12'h007, wa ^ 48'h8000_0000_0000, wb, 80);
      widths(0, 0, 0, 0, 0);
      @(posedge clk_in);
      #2 hot = 1'b0;
      repeat (20) @(posedge clk_in);
      chk("shutdown", 32'h1, shut);
      #2 cool = 1'b1;
      wait_shut(1'b0);
      #2 cool = 1'b0;
      $display("test thermal done");
   endtask

   // Dropped word keeps earlier values; counters restart once per frame
   task automatic t_refresh();
      clr();
      ctrl.frame(12'h007, wa, wb, 80);
      widths(7, 2, 0, 1, 3);
      $display("test refresh done");
   endtask

   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_in = 1'b1;
      hot = 1'b0;
      cool = 1'b0;
      n_errors = 0;
      checked = 0;
      wa = mk(10'h000, 10'h001, 10'h005, 10'h014);
      wb = mk(10'h2AA, 10'h155, 10'h3FF, 10'h0F0);
      wc = mk(10'h002, 10'h000, 10'h001, 10'h003);
      // Link reset needs serial edges after release
      fork
         begin
            repeat (6) @(posedge clk_in);
            #2 rst_in = 1'b0;
         end
         ctrl.idle(8);
      join
      t_reset();
      t_forward();
      t_pwm();
      t_thermal();
      t_refresh();
      conclude();
   end
endmodule
